// ==== fault_status_pkg.sv ====
// Constants for the fault status flag block
package fault_status_pkg;
   localparam int          STATUS_WIDTH   = 8;
   localparam int          BIT_FAULT      = 7;
   localparam int          BIT_DISCHARGE  = 6;
   localparam int          BIT_RESET_IND  = 5;
   localparam int          BIT_UNDERVOLT  = 4;
   localparam int          BIT_OVERTEMP   = 3;
   localparam logic [7:0]  STATUS_RESET   = 8'h00;
   localparam int          NUM_FAULTS     = 3;
   localparam int          SYNC_STAGES    = 2;
   typedef enum logic [1:0] {
      ST_ACTIVE = 2'b01,
      ST_ERROR  = 2'b10
   } fault_state_t;
endpackage

// ==== fault_status_flags.sv ====
// Fault status flags: discharge, undervoltage, over-temperature, reset
//
// Operation
// - Discharge failure sets its flag
// - Read clears gone faults; fault-bit clear also clears only gone faults
// - Fault flag set raises alert, enters Error
// - Output below minimum sets undervoltage flag
// - Over-temperature above shutdown threshold sets flag
// - Reset bit 5, undervoltage 4, temperature 3
// - Reset indicator set at every power-up
// - Reset indicator clears on read or enable toggle
// - Reset indicator never alerts nor forces Error
// - Reset indicator kept through Sleep
// - Disabling power switch clears fault-state bit
// - Alert pin tracked apart from fault-state bit
// - Fault bit set on Error; write 0 rechecks
// - Auto recovery clears fault bit when clean
`timescale 1ns/1ns
`default_nettype none
module fault_status_flags
   import fault_status_pkg::*;
(
   input  wire logic        mclk,
   input  wire logic        reset_n,
   input  wire logic        discharge_fail_cond,
   input  wire logic        undervolt_cond,
   input  wire logic        thermal_shutdown_threshold,
   input  wire logic        other_status_set,
   input  wire logic        power_switch_enable,
   input  wire logic        auto_recovery,
   input  wire logic        sleep_active,
   input  wire logic        status_rd,
   input  wire logic        status_wr,
   input  wire logic [7:0]  status_wdata,
   input  wire logic        alert_ack,
   output logic [7:0]       status_rdata,
   output logic             status_rvalid,
   output logic             alert_n_o,
   output logic             alert_n_oe,
   output logic             error_state
);
   import fault_status_pkg::*;

   logic [1:0]            rst_sync;
   logic                  rst_n;
   logic [NUM_FAULTS-1:0] cond_s1;
   logic [NUM_FAULTS-1:0] cond_s2;
   logic [NUM_FAULTS-1:0] fault;
   logic [NUM_FAULTS-1:0] next_fault;
   logic                  reset_ind;
   logic                  next_reset_ind;
   logic                  fault_bit;
   logic                  next_fault_bit;
   logic                  enable_q;
   logic                  enable_seen;
   logic                  enable_toggle;
   logic                  clear_pending;
   logic                  next_clear_pending;
   logic                  alert;
   logic                  next_alert;
   fault_state_t          state;
   fault_state_t          next_state;
   logic [7:0]            next_rdata;
   logic                  fault_bit_clear;
   logic [NUM_FAULTS-1:0] new_set;

   // Reset released through two flops so release is clean on mclk
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         rst_sync <= 2'h0;
      end else begin
         rst_sync <= {rst_sync[0], 1'b1};
      end
   end
   assign rst_n = rst_sync[1];

   // Analog comparator levels are asynchronous to mclk
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         cond_s1 <= 3'h0;
         cond_s2 <= 3'h0;
      end else begin
         cond_s1 <= {thermal_shutdown_threshold, undervolt_cond,
                     discharge_fail_cond};
         cond_s2 <= cond_s1;
      end
   end

   always_comb begin
      fault_bit_clear = (status_wr && !status_wdata[BIT_FAULT])
                        || (enable_q && !power_switch_enable)
                        || (auto_recovery && cond_s2 == 3'h0);
      new_set = cond_s2 & ~fault;
      // Gate the first cycle so the reset value of enable_q is no toggle
      enable_toggle = enable_seen && (enable_q != power_switch_enable);
      // Index 0 discharge, 1 undervoltage, 2 over-temperature
      next_fault = fault | cond_s2;
      if (clear_pending) begin
         next_fault = (fault & cond_s2) | cond_s2;
      end
      if (fault_bit && fault_bit_clear) begin
         next_fault = cond_s2;
      end
      next_reset_ind = reset_ind;
      if (clear_pending || enable_toggle) begin
         next_reset_ind = 1'b0;
      end
      next_state     = state;
      next_fault_bit = fault_bit;
      if (new_set != 3'h0) begin
         next_state     = ST_ERROR;
         next_fault_bit = 1'b1;
      end else if (fault_bit_clear) begin
         next_fault_bit = 1'b0;
         // Recheck: stay in Error while anything still flags
         if (cond_s2 == 3'h0 && !other_status_set) begin
            next_state = ST_ACTIVE;
         end
      end
      // Alert is its own latch; the fault bit does not drive it
      next_alert = alert;
      if (new_set != 3'h0) begin
         next_alert = 1'b1;
      end else if (alert_ack) begin
         next_alert = 1'b0;
      end
      next_rdata = 8'h00;
      next_rdata[BIT_FAULT]     = fault_bit;
      next_rdata[BIT_DISCHARGE] = fault[0];
      next_rdata[BIT_RESET_IND] = reset_ind;
      next_rdata[BIT_UNDERVOLT] = fault[1];
      next_rdata[BIT_OVERTEMP]  = fault[2];
      // Clear lands the cycle after data goes out
      next_clear_pending = status_rd;
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         fault         <= 3'h0;
         reset_ind     <= 1'b1;
         fault_bit     <= 1'b0;
         enable_q      <= 1'b0;
         enable_seen   <= 1'b0;
         clear_pending <= 1'b0;
         alert         <= 1'b0;
         state         <= ST_ACTIVE;
         status_rdata  <= STATUS_RESET;
         status_rvalid <= 1'b0;
         alert_n_o     <= 1'b1;
         alert_n_oe    <= 1'b0;
         error_state   <= 1'b0;
      end else begin
         fault         <= next_fault;
         reset_ind     <= next_reset_ind;
         fault_bit     <= next_fault_bit;
         enable_q      <= power_switch_enable;
         enable_seen   <= 1'b1;
         clear_pending <= next_clear_pending;
         alert         <= next_alert;
         state         <= next_state;
         status_rdata  <= status_rd ? next_rdata : status_rdata;
         status_rvalid <= status_rd;
         alert_n_o     <= 1'b0;
         alert_n_oe    <= next_alert;
         error_state   <= (next_state == ST_ERROR);
      end
   end

   // Open-drain alert only ever pulls low
   a_alert_on_fault: assert property (
      @(posedge mclk) disable iff (!rst_n)
      (new_set != 3'h0) |=> alert_n_oe)
      else $error("alert not raised after fault flag set");
   a_alert_drive: assert property (
      @(posedge mclk) disable iff (!rst_n)
      alert_n_oe |-> !alert_n_o)
      else $error("alert pin enabled while not low");
   a_reset_no_alert: assert property (
      @(posedge mclk) disable iff (!rst_n)
      (new_set == 3'h0 && !alert) |=> !alert)
      else $error("alert rose without fault flag");
   a_discharge_set: assert property (
      @(posedge mclk) disable iff (!rst_n)
      cond_s2[0] |=> fault[0])
      else $error("discharge flag not set");
   a_overtemp_set: assert property (
      @(posedge mclk) disable iff (!rst_n)
      cond_s2[2] |=> fault[2])
      else $error("over-temperature flag not set");
   a_set_wins_read: assert property (
      @(posedge mclk) disable iff (!rst_n)
      (clear_pending && cond_s2[2]) |=> fault[2])
      else $error("read lost a live over-temperature");
   a_read_clears: assert property (
      @(posedge mclk) disable iff (!rst_n)
      (clear_pending && !cond_s2[0] && !(fault_bit && fault_bit_clear))
      |=> !fault[0])
      else $error("discharge flag not cleared by read");
   a_rdata_fields: assert property (
      @(posedge mclk) disable iff (!rst_n)
      status_rd |=> (status_rdata[BIT_RESET_IND] == $past(reset_ind)
                     && status_rdata[BIT_UNDERVOLT] == $past(fault[1])
                     && status_rdata[BIT_OVERTEMP] == $past(fault[2])))
      else $error("status bits out of place");
   a_reset_ind_read: assert property (
      @(posedge mclk) disable iff (!rst_n)
      status_rd |=> ##1 !reset_ind)
      else $error("reset indicator survived read");
   a_toggle_clear: assert property (
      @(posedge mclk) disable iff (!rst_n)
      enable_toggle |=> !reset_ind)
      else $error("reset indicator survived enable toggle");
   a_clear_waits: assert property (
      @(posedge mclk) disable iff (!rst_n)
      (status_rd && !clear_pending && enable_q == power_switch_enable)
      |=> $stable(reset_ind))
      else $error("read cleared before data returned");
   a_manual_clear: assert property (
      @(posedge mclk) disable iff (!rst_n)
      (status_wr && !status_wdata[BIT_FAULT] && new_set == 3'h0)
      |=> !fault_bit)
      else $error("fault bit kept after write of zero");
   a_disable_clear: assert property (
      @(posedge mclk) disable iff (!rst_n)
      (enable_q && !power_switch_enable && new_set == 3'h0)
      |=> !fault_bit)
      else $error("fault bit kept after switch disable");
   a_auto_recover: assert property (
      @(posedge mclk) disable iff (!rst_n)
      (auto_recovery && cond_s2 == 3'h0) |=> !fault_bit)
      else $error("fault bit kept under auto recovery");
   a_error_entry: assert property (
      @(posedge mclk) disable iff (!rst_n)
      (new_set != 3'h0) |=> (fault_bit && state == ST_ERROR))
      else $error("Error state not entered on fault");
   a_sync_delay: assert property (
      @(posedge mclk) disable iff (!rst_n)
      ($rose(cond_s2[1]) && $past(cond_s1[1], 1)) |=> fault[1])
      else $error("undervoltage flag missed");
   a_sleep_keep: assert property (
      @(posedge mclk) disable iff (!rst_n)
      (sleep_active && !clear_pending && $stable(power_switch_enable)
       && enable_q == power_switch_enable) |=> $stable(reset_ind))
      else $error("reset indicator changed in Sleep");
endmodule
`default_nettype wire

// ==== status_host.sv ====
// Host model: issues status reads and fault-bit writes
`timescale 1ns/1ns
`default_nettype none
module status_host (
   input  wire logic       mclk,
   output logic            status_rd,
   output logic            status_wr,
   output logic [7:0]      status_wdata
);
   initial begin
      status_rd = 1'b0;
      status_wr = 1'b0;
      status_wdata = 8'hFF;
   end
   // Called on a rising edge; gaps let clear-on-read land before next read
   task automatic rd();
      status_rd <= 1'b1;
      @(posedge mclk);
      status_rd <= 1'b0;
      repeat (3) @(posedge mclk);
   endtask
   // Writing 0 to the fault bit clears it by hand; Error is left only if nothing still flags
   task automatic wr(input logic [7:0] d);
      status_wr <= 1'b1;
      status_wdata <= d;
      @(posedge mclk);
      status_wr <= 1'b0;
      status_wdata <= ~d;
      repeat (3) @(posedge mclk);
   endtask
endmodule
`default_nettype wire

// ==== fault_status_flags_tb.sv ====
// Self-checking bench for the fault status flags
`timescale 1ns/1ns
`default_nettype none
module fault_status_flags_tb;
   import fault_status_pkg::*;
   logic       mclk, reset_n, dis, uv, ot, oth, pse, auto_r, slp, ack;
   logic       status_rd, status_wr, status_rvalid;
   logic       alert_n_o, alert_n_oe, error_state;
   logic [7:0] status_wdata, status_rdata;
   logic [7:0] exp_q[$];
   int         miscompares, n_tests, cyc;
   fault_status_flags u_fault_status_flags (.mclk(mclk), .reset_n(reset_n),
      .discharge_fail_cond(dis), .undervolt_cond(uv),
      .thermal_shutdown_threshold(ot), .other_status_set(oth),
      .power_switch_enable(pse), .auto_recovery(auto_r),
      .sleep_active(slp), .status_rd(status_rd), .status_wr(status_wr),
      .status_wdata(status_wdata), .alert_ack(ack),
      .status_rdata(status_rdata), .status_rvalid(status_rvalid),
      .alert_n_o(alert_n_o), .alert_n_oe(alert_n_oe),
      .error_state(error_state));
   status_host u_status_host (.mclk(mclk), .status_rd(status_rd),
      .status_wr(status_wr), .status_wdata(status_wdata));
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp) begin
         miscompares++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic rd(input logic [7:0] exp);
      exp_q.push_back(exp);
      u_status_host.rd();
   endtask
   task automatic wt(input int n);
      repeat (n) @(posedge mclk);
   endtask
   // Pin and state check after the edge has settled
   task automatic pins(input logic [7:0] exp);
      #1;
      chk({5'h00, alert_n_o, alert_n_oe, error_state}, exp);
      @(posedge mclk);
   endtask
   task automatic end_of_test();
      $display("%0d mismatches in %0d checks", miscompares, n_tests);
      if (miscompares == 0 && n_tests > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // Read data is taken at the falling edge, clear of the launch edge
   always @(negedge mclk) begin
      if (status_rvalid === 1'b1) begin
         if (exp_q.size() == 0) chk(status_rdata, 8'hEE);
         else chk(status_rdata, exp_q.pop_front());
      end
   end
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 3000) begin
         miscompares++;
         end_of_test();
      end
   end
   initial begin
      logic k;
      {dis, uv, ot, oth, auto_r, slp, ack} = 7'h00;
      pse = 1'b1;
      reset_n = 1'b0;
      void'($urandom(91));
      wt(20);
      reset_n <= 1'b1;
      wt(3);
      slp <= 1'b1;
      rd(8'h20);
      pins(8'h00);
      // Reset indicator seen: host reloads its settings
      u_status_host.wr(8'h00);
      slp <= 1'b0;
      rd(8'h00);
      uv <= 1'b1;
      wt(6);
      pins(8'h03);
      rd(8'h90);
      rd(8'h90);
      uv <= 1'b0;
      wt(4);
      rd(8'h90);
      rd(8'h80);
      oth <= 1'b1;
      u_status_host.wr(8'h00);
      pins(8'h03);
      oth <= 1'b0;
      u_status_host.wr(8'h00);
      pins(8'h02);
      ack <= 1'b1;
      wt(1);
      ack <= 1'b0;
      wt(2);
      pins(8'h00);
      for (int i = 0; i < 4; i++) begin
         k = 1'($urandom_range(1, 0));
         if (k) dis <= 1'b1;
         else ot <= 1'b1;
         wt(6);
         pins(8'h03);
         rd(k ? 8'hC0 : 8'h88);
         dis <= 1'b0;
         ot <= 1'b0;
         wt(4);
         pse <= 1'b0;
         wt(4);
         pins(8'h02);
         rd(8'h00);
         pse <= 1'b1;
         ack <= 1'b1;
         wt(1);
         ack <= 1'b0;
         wt(3);
      end
      auto_r <= 1'b1;
      ot <= 1'b1;
      wt(6);
      ot <= 1'b0;
      wt(8);
      pins(8'h02);
      rd(8'h00);
      // Second power-up must raise the reset indicator again
      reset_n <= 1'b0;
      wt(2);
      reset_n <= 1'b1;
      wt(3);
      rd(8'h20);
      pins(8'h00);
      end_of_test();
   end
endmodule
`default_nettype wire
